//--- rtl/rsc_cfg.svh
// Offsets, field positions, reset values, command codes and timing for the state control block
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSC_ADDR_STATUS        6'h01
`define RSC_ADDR_STATE         6'h02
`define RSC_ADDR_CTRL_ONE      6'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_CMD_MSB            4
`define RSC_TRAC_MSB           7
`define RSC_TRAC_LSB           5
`define RSC_CTL_EXT_IRQ        6
`define RSC_CTL_AUTO_CRC       5
`define RSC_CTL_RX_BUF         4
`define RSC_CTL_SPI_MSB        3
`define RSC_CTL_SPI_LSB        2
`define RSC_CTL_MASK_MODE      1
`define RSC_CTL_POLARITY       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_CTRL_ONE_RST       8'h22
`define RSC_CMD_RST            5'h00
`define RSC_TRAC_RST           3'h0

// ----------------------------------------------------------------
// Command and status codes
// ----------------------------------------------------------------
`define RSC_NO_OPERATION_CODE  5'h00
`define RSC_TX_START_CODE      5'h02
`define RSC_FORCED_OFF_CODE    5'h03
`define RSC_FORCED_PLL_CODE    5'h04
`define RSC_RX_LISTEN_CODE     5'h06
`define RSC_RADIO_IDLE_CODE    5'h08
`define RSC_PLL_READY_CODE     5'h09
`define RSC_AUTO_ACK_RX_CODE   5'h16
`define RSC_AUTO_RETRY_TX_CODE 5'h19
`define RSC_ST_P_ON            5'h00
`define RSC_ST_BUSY_RX         5'h01
`define RSC_ST_BUSY_TX         5'h02
`define RSC_ST_BUSY_RX_AACK    5'h11
`define RSC_ST_BUSY_TX_ARET    5'h12
`define RSC_ST_PENDING         5'h1F
`define RSC_TRAC_SUCCESS       3'h0
`define RSC_TRAC_INVALID       3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSC_CLK_NS             10
`define RSC_SYMBOL_NS          16000
`define RSC_SETTLE_NS          1000

`endif

//--- rtl/rsc_pkg.sv
// Types shared by the radio state command block
package rsc_pkg;

  // ----------------------------------------------------------------
  // Transceiver states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    rsc_p_on,
    rsc_radio_idle,
    rsc_pll_on,
    rsc_rx_on,
    rsc_busy_rx,
    rsc_tx_wait,
    rsc_busy_tx,
    rsc_rx_aack,
    rsc_busy_rx_aack,
    rsc_tx_aret,
    rsc_busy_tx_aret,
    rsc_transition_pending_state
  } rsc_state_t;

endpackage : rsc_pkg

//--- rtl/rsc_state_control.sv
// Radio state command interpreter with state and control registers
// How it works
// (R01) Each write of an accepted command code other than 00 nop to the command field starts a transition toward the coded state.
// (R02) Codes 00 nop, 02 tx, 03 off, 04 pll, 06 rx, 08 idle, 09 pll.
// (R03) Codes 16 and 19 are accepted only in extended operating mode.
// (R04) Command field reads zero, the no-operation code, after reset.
// (R05) Frame transmission begins one symbol period after the transmit start command.
// (R06) Forced pll-on is ignored in power-on state; the bench issues it there and checks status stays 00.
// (R07) Host confirms each transition by reading the status register at 0x01.
// (R08) Same command field and codes serve basic and extended modes.
// (R09) Control register 0x04 holds irq, checksum, buffer, spi mode, mask, polarity.
// (R10) Control register resets with checksum and mask mode set, rest clear.
// (R11) State register 0x02: command in 4:0, read-only transaction result in 7:5.
// (R12) Status reads 1F during transition; host waits for a stable code.
// (R13) Rising edge on the trigger pin starts transmission in ready states.
// (R14) Reserved command codes leave the current state unchanged.
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_state_control
  import rsc_pkg::*;
#(
  parameter int SYMBOL_NS = `RSC_SYMBOL_NS,
  parameter int SETTLE_NS = `RSC_SETTLE_NS,
  parameter int CNT_W     = 12
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register port behind the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Pins and mode strap
  input  wire logic       sleep_transmit_trigger_pin,
  input  wire logic       ext_mode_en,
  // Radio datapath handshakes
  input  wire logic       rx_frame_start,
  input  wire logic       rx_frame_done,
  input  wire logic       tx_frame_done,
  output logic            tx_frame_start,
  // State and configuration outputs
  output logic      [4:0] transceiver_status_field,
  output logic            ext_rx_start_irq_enable,
  output logic            tx_auto_crc_on,
  output logic            receive_buffer_control,
  output logic      [1:0] spi_cmd_mode,
  output logic            irq_mask_mode,
  output logic            irq_polarity
);

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  // Least times round up to whole cycles
  localparam int SYM_CYC    = (SYMBOL_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;

  // ----------------------------------------------------------------
  // Status code of a state
  // ----------------------------------------------------------------
  function automatic logic [4:0] status_code(input rsc_state_t s);
    logic [4:0] c;
    c = `RSC_ST_P_ON;
    unique case (s)
      rsc_p_on:                     c = `RSC_ST_P_ON;
      rsc_radio_idle:               c = `RSC_RADIO_IDLE_CODE;
      rsc_pll_on:                   c = `RSC_PLL_READY_CODE;
      rsc_rx_on:                    c = `RSC_RX_LISTEN_CODE;
      rsc_busy_rx:                  c = `RSC_ST_BUSY_RX;
      rsc_tx_wait:                  c = `RSC_ST_BUSY_TX;
      rsc_busy_tx:                  c = `RSC_ST_BUSY_TX;
      rsc_rx_aack:                  c = `RSC_AUTO_ACK_RX_CODE;
      rsc_busy_rx_aack:             c = `RSC_ST_BUSY_RX_AACK;
      rsc_tx_aret:                  c = `RSC_AUTO_RETRY_TX_CODE;
      rsc_busy_tx_aret:             c = `RSC_ST_BUSY_TX_ARET;
      rsc_transition_pending_state: c = `RSC_ST_PENDING;
    endcase
    return c;
  endfunction : status_code

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [2:0] trig_sync;
  logic [1:0] ext_sync;
  logic       trig_rise;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_sync <= 3'h0;
      ext_sync  <= 2'h0;
    end else begin
      trig_sync <= {trig_sync[1:0], sleep_transmit_trigger_pin};
      ext_sync  <= {ext_sync[0], ext_mode_en};
    end
  end

  // Edge taken between second and third stage, never the first
  assign trig_rise = trig_sync[1] & ~trig_sync[2];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] state_ctrl_one;
  logic [7:0] next_ctrl_one;
  logic [4:0] state_command_field;
  logic [4:0] next_command_field;
  logic [7:0] next_rdata;
  logic [2:0] trac_result;
  logic       cmd_wr;

  assign cmd_wr = reg_wr && (reg_addr == `RSC_ADDR_STATE);

  always_comb begin
    next_ctrl_one      = state_ctrl_one;
    next_command_field = state_command_field;
    next_rdata         = reg_rdata;
    if (reg_wr && (reg_addr == `RSC_ADDR_CTRL_ONE)) begin
      next_ctrl_one = reg_wdata; // R09
    end
    if (cmd_wr) begin
      next_command_field = reg_wdata[`RSC_CMD_MSB:0]; // R11
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `RSC_ADDR_STATUS:   next_rdata = {3'h0, transceiver_status_field}; // R07
        `RSC_ADDR_STATE:    next_rdata = {trac_result, state_command_field}; // R11
        `RSC_ADDR_CTRL_ONE: next_rdata = state_ctrl_one;
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ctrl_one      <= `RSC_CTRL_ONE_RST; // R10
      state_command_field <= `RSC_CMD_RST; // R04
      reg_rdata           <= 8'h00;
    end else begin
      state_ctrl_one      <= next_ctrl_one;
      state_command_field <= next_command_field;
      reg_rdata           <= next_rdata;
    end
  end

  assign ext_rx_start_irq_enable = state_ctrl_one[`RSC_CTL_EXT_IRQ];
  assign tx_auto_crc_on          = state_ctrl_one[`RSC_CTL_AUTO_CRC];
  assign receive_buffer_control  = state_ctrl_one[`RSC_CTL_RX_BUF];
  assign spi_cmd_mode            = state_ctrl_one[`RSC_CTL_SPI_MSB:`RSC_CTL_SPI_LSB];
  assign irq_mask_mode           = state_ctrl_one[`RSC_CTL_MASK_MODE];
  assign irq_polarity            = state_ctrl_one[`RSC_CTL_POLARITY];

  // ----------------------------------------------------------------
  // Transceiver state machine
  // ----------------------------------------------------------------
  rsc_state_t       state;
  rsc_state_t       next_state;
  rsc_state_t       target;
  rsc_state_t       next_target;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [2:0]       next_trac;
  logic             next_tx_start;
  logic [4:0]       cmd;
  logic             steady;

  assign cmd    = reg_wdata[`RSC_CMD_MSB:0];
  // P_ON accepts only the idle and forced-off commands
  assign steady = (state != rsc_transition_pending_state) && (state != rsc_p_on);

  always_comb begin
    next_state    = state;
    next_target   = target;
    next_cnt      = cnt;
    next_trac     = trac_result;
    next_tx_start = 1'b0;
    unique case (state)
      rsc_transition_pending_state: begin
        if (cnt == '0) begin
          next_state = target;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      rsc_tx_wait: begin
        if (cnt == '0) begin
          next_state    = target; // R05
          next_tx_start = 1'b1;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      rsc_pll_on, rsc_tx_aret: begin
        if (trig_rise) begin
          next_state  = rsc_tx_wait; // R13
          next_target = (state == rsc_tx_aret) ? rsc_busy_tx_aret : rsc_busy_tx;
          next_cnt    = CNT_W'(SYM_CYC - 1);
          if (state == rsc_tx_aret) begin
            next_trac = `RSC_TRAC_INVALID;
          end
        end
      end
      rsc_busy_tx: begin
        if (tx_frame_done) begin
          next_state = rsc_pll_on;
        end
      end
      rsc_busy_tx_aret: begin
        if (tx_frame_done) begin
          next_state = rsc_tx_aret;
          next_trac  = `RSC_TRAC_SUCCESS;
        end
      end
      rsc_rx_on: begin
        if (rx_frame_start) begin
          next_state = rsc_busy_rx;
        end
      end
      rsc_rx_aack: begin
        if (rx_frame_start) begin
          next_state = rsc_busy_rx_aack;
          next_trac  = `RSC_TRAC_INVALID;
        end
      end
      rsc_busy_rx: begin
        if (rx_frame_done) begin
          next_state = rsc_rx_on;
        end
      end
      rsc_busy_rx_aack: begin
        if (rx_frame_done) begin
          next_state = rsc_rx_aack;
          next_trac  = `RSC_TRAC_SUCCESS;
        end
      end
      rsc_p_on, rsc_radio_idle: begin
        next_state = state;
      end
    endcase
    // Host writes override internal events; one decoder for both modes
    if (cmd_wr) begin // R01 R08
      unique case (cmd) // R02
        `RSC_FORCED_OFF_CODE: begin
          // Forced off aborts anything, even a pending transition
          next_state    = rsc_radio_idle;
          next_tx_start = 1'b0;
        end
        `RSC_TX_START_CODE: begin
          if (state == rsc_pll_on || state == rsc_tx_aret) begin
            next_state  = rsc_tx_wait; // R05
            next_target = (state == rsc_tx_aret) ? rsc_busy_tx_aret : rsc_busy_tx;
            next_cnt    = CNT_W'(SYM_CYC - 1);
          end
        end
        `RSC_FORCED_PLL_CODE: begin
          if (steady) begin // R06
            next_state    = rsc_transition_pending_state;
            next_target   = rsc_pll_on;
            next_cnt      = CNT_W'(SETTLE_CYC - 1);
            next_tx_start = 1'b0;
          end
        end
        `RSC_RADIO_IDLE_CODE, `RSC_RX_LISTEN_CODE, `RSC_PLL_READY_CODE: begin
          if (state != rsc_transition_pending_state &&
              (state != rsc_p_on || cmd == `RSC_RADIO_IDLE_CODE)) begin
            next_state  = rsc_transition_pending_state; // R12
            next_target = (cmd == `RSC_RADIO_IDLE_CODE) ? rsc_radio_idle :
                          (cmd == `RSC_RX_LISTEN_CODE)  ? rsc_rx_on : rsc_pll_on;
            next_cnt    = CNT_W'(SETTLE_CYC - 1);
          end
        end
        `RSC_AUTO_ACK_RX_CODE, `RSC_AUTO_RETRY_TX_CODE: begin
          if (steady && ext_sync[1]) begin // R03
            next_state  = rsc_transition_pending_state;
            next_target = (cmd == `RSC_AUTO_ACK_RX_CODE) ? rsc_rx_aack : rsc_tx_aret;
            next_cnt    = CNT_W'(SETTLE_CYC - 1);
            next_trac   = `RSC_TRAC_INVALID;
          end
        end
        default: begin
          next_state = next_state; // R14
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state                    <= rsc_p_on;
      target                   <= rsc_p_on;
      cnt                      <= '0;
      trac_result              <= `RSC_TRAC_RST;
      tx_frame_start           <= 1'b0;
      transceiver_status_field <= `RSC_ST_P_ON;
    end else begin
      state                    <= next_state;
      target                   <= next_target;
      cnt                      <= next_cnt;
      trac_result              <= next_trac;
      tx_frame_start           <= next_tx_start;
      transceiver_status_field <= status_code(next_state); // R12
    end
  end

endmodule : rsc_state_control

//--- sim/rsc_state_control_asserts.sv
// Port checker for the radio state command block
`timescale 1ns/1ps
module rsc_state_control_asserts #(
  parameter int SYMBOL_NS = 16000,
  parameter int SETTLE_NS = 1000,
  parameter int CNT_W     = 12
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins and datapath
  input wire logic       sleep_transmit_trigger_pin,
  input wire logic       ext_mode_en,
  input wire logic       rx_frame_start,
  input wire logic       rx_frame_done,
  input wire logic       tx_frame_done,
  input wire logic       tx_frame_start,
  // State and configuration
  input wire logic [4:0] transceiver_status_field,
  input wire logic       ext_rx_start_irq_enable,
  input wire logic       tx_auto_crc_on,
  input wire logic       receive_buffer_control,
  input wire logic [1:0] spi_cmd_mode,
  input wire logic       irq_mask_mode,
  input wire logic       irq_polarity
);
  // ----
  // Helpers
  // ----
  localparam int SYM        = (SYMBOL_NS + 9) / 10;
  // Settle time plus two cycles of slack; status updates in the same cycle as the state
  localparam int SETTLE_MAX = (SETTLE_NS + 9) / 10 + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic       st_wr = reg_wr && reg_addr == 6'h02;
  wire logic [4:0] st    = transceiver_status_field;
  wire logic [6:0] ctl   = {ext_rx_start_irq_enable, tx_auto_crc_on, receive_buffer_control,
                            spi_cmd_mode, irq_mask_mode, irq_polarity};
  // Counts from a transmit start so the symbol delay is checked exactly
  int unsigned     wait_cnt;
  int unsigned     next_wait_cnt;
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (tx_frame_start) next_wait_cnt = 0;
    else if (st_wr && reg_wdata[4:0] == 5'h02 && (st == 5'h09 || st == 5'h19)) next_wait_cnt = 1;
    else if (wait_cnt != 0) next_wait_cnt = wait_cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (!resetn) wait_cnt <= 0;
    else wait_cnt <= next_wait_cnt;
  end
  sequence pend_s; (st == 5'h1F) [*8]; endsequence
  sequence leave_s; ##[1:SETTLE_MAX] st != 5'h1F; endsequence
  // ----
  // Assertions
  // ----
  reset_vals_a: assert property ($rose(resetn) |-> st == 5'h00 && ctl == 7'h22)
    else $error("reset values wrong");
  idle_cmd_a: assert property (st_wr && reg_wdata[4:0] == 5'h08 && st == 5'h00
    |=> pend_s ##[1:120] st == 5'h08) else $error("idle command not taken");
  forced_off_a: assert property (st_wr && reg_wdata[4:0] == 5'h03 |=> st == 5'h08)
    else $error("forced off late");
  pll_pon_a: assert property (st_wr && reg_wdata[4:0] == 5'h04 && st == 5'h00 |=> st == 5'h00)
    else $error("forced pll acted in power on");
  reserved_a: assert property (st_wr && !(reg_wdata[4:0] inside {5'h00, 5'h02, 5'h03,
    5'h04, 5'h06, 5'h08, 5'h09, 5'h16, 5'h19}) |=> $stable(st)) else $error("reserved acted");
  ext_off_a: assert property (st_wr && reg_wdata[4:0] inside {5'h16, 5'h19} && !ext_mode_en
    && !$past(ext_mode_en) && !$past(ext_mode_en, 2) |=> $stable(st)) else $error("ext code");
  ctrl_wr_a: assert property (reg_wr && reg_addr == 6'h04 |=> ctl == 7'($past(reg_wdata)))
    else $error("control bits wrong");
  // Pulse is launched SYM edges after the write and seen one edge later
  tx_delay_a: assert property ($rose(tx_frame_start) && wait_cnt != 0 |-> wait_cnt == SYM + 1)
    else $error("transmit delay wrong");
  rd_status_a: assert property (reg_rd && reg_addr == 6'h01 |=> reg_rdata == {3'h0, $past(st)})
    else $error("status read wrong");
  settle_a: assert property ($rose(st == 5'h1F) |-> leave_s)
    else $error("transition never ends");
  trig_a: assert property ($rose(sleep_transmit_trigger_pin) && st == 5'h09 |-> ##[2:8] st == 5'h02)
    else $error("trigger ignored");
endmodule : rsc_state_control_asserts

bind rsc_state_control rsc_state_control_asserts #(.SYMBOL_NS(SYMBOL_NS), .SETTLE_NS(SETTLE_NS),
  .CNT_W(CNT_W)) i_rsc_state_control_asserts (.*);

//--- sim/rsc_host_model.sv
// Host controller model issuing register accesses and state commands
`timescale 1ns/1ps
module rsc_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 6'h3F;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd
  // Polls status until the transition is over, for at most 40 reads, before anything else is sent
  task automatic cmd(input logic [4:0] c, output logic [7:0] st);
    int n;
    n = 0;
    wr(6'h02, {3'h0, c});
    do begin
      rd(6'h01, st);
      n++;
    end while (st === 8'h1F && n < 40);
  endtask : cmd
endmodule : rsc_host_model

//--- sim/test_radio_state_command_control.sv
// Self-checking bench for the radio state command block
`timescale 1ns/1ps
module test_radio_state_command_control;
  // ----
  // Signals
  // ----
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       sleep_transmit_trigger_pin = 1'b0;
  logic       ext_mode_en = 1'b0;
  logic       rx_frame_start = 1'b0;
  logic       rx_frame_done = 1'b0;
  logic       tx_frame_done = 1'b0;
  logic       tx_frame_start, ext_rx_start_irq_enable, tx_auto_crc_on;
  logic       receive_buffer_control, irq_mask_mode, irq_polarity;
  logic [1:0] spi_cmd_mode;
  logic [4:0] transceiver_status_field;
  int         checks = 0;
  int         miscompares = 0;
  int         cycles = 0;
  int         n;
  always #5 clk = ~clk;
  // Short symbol and settle times keep the run brief
  rsc_state_control #(.SYMBOL_NS(1000), .SETTLE_NS(100)) i_rsc_state_control (.*);
  rsc_host_model i_rsc_host_model (.*);
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rdc(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_rsc_host_model.rd(a, d);
    check(what, d, exp);
  endtask : rdc
  task automatic cmdc(input string what, input logic [4:0] c, input logic [7:0] exp);
    logic [7:0] st;
    i_rsc_host_model.cmd(c, st);
    check(what, st, exp);
  endtask : cmdc
  // Selector: 0 receive start, 1 receive done, 2 transmit done
  task automatic pulse(input int which);
    @(posedge clk) #1;
    rx_frame_start = (which == 0);
    rx_frame_done  = (which == 1);
    tx_frame_done  = (which == 2);
    @(posedge clk) #1;
    rx_frame_start = 1'b0;
    rx_frame_done  = 1'b0;
    tx_frame_done  = 1'b0;
  endtask : pulse
  task automatic wait_pulse(output int k);
    k = 0;
    while (tx_frame_start !== 1'b1 && k < 300) begin
      @(posedge clk) #1;
      k++;
    end
  endtask : wait_pulse
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // ----
  // Tests
  // ----
  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rdc("ctrl reset", 6'h04, 8'h22);
    rdc("state reset", 6'h02, 8'h00);
    i_rsc_host_model.wr(6'h04, 8'hDD);
    rdc("ctrl rw", 6'h04, 8'hDD);
    check("ctrl pins", {1'b0, ext_rx_start_irq_enable, tx_auto_crc_on, receive_buffer_control,
      spi_cmd_mode, irq_mask_mode, irq_polarity}, 8'h5D);
    i_rsc_host_model.wr(6'h01, 8'h08);
    rdc("unmapped", 6'h3F, 8'h00);
    cmdc("pll in pon", 5'h04, 8'h00);
    i_rsc_host_model.wr(6'h02, 8'hE5);
    rdc("cmd field", 6'h02, 8'h05);
    rdc("reserved", 6'h01, 8'h00);
    cmdc("idle", 5'h08, 8'h08);
    cmdc("aack no ext", 5'h16, 8'h08);
    cmdc("rx listen", 5'h06, 8'h06);
    pulse(0);
    rdc("busy rx", 6'h01, 8'h01);
    pulse(1);
    cmdc("forced pll", 5'h04, 8'h09);
    i_rsc_host_model.wr(6'h02, 8'h02);
    wait_pulse(n);
    check("tx delay", 8'(n), 8'd100);
    rdc("busy tx", 6'h01, 8'h02);
    pulse(2);
    rdc("tx done", 6'h01, 8'h09);
    sleep_transmit_trigger_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1 sleep_transmit_trigger_pin = 1'b0;
    rdc("trigger", 6'h01, 8'h02);
    wait_pulse(n);
    pulse(2);
    ext_mode_en = 1'b1;
    repeat (4) @(posedge clk);
    cmdc("aack on", 5'h16, 8'h16);
    rdc("trac invalid", 6'h02, 8'hF6);
    pulse(0);
    rdc("busy aack", 6'h01, 8'h11);
    pulse(1);
    cmdc("aret on", 5'h19, 8'h19);
    i_rsc_host_model.wr(6'h02, 8'h02);
    wait_pulse(n);
    check("aret delay", 8'(n), 8'd100);
    rdc("busy aret", 6'h01, 8'h12);
    pulse(2);
    rdc("trac success", 6'h02, 8'h02);
    cmdc("pll from aret", 5'h09, 8'h09);
    cmdc("forced off", 5'h03, 8'h08);
    final_report;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report;
    end
  end
endmodule : test_radio_state_command_control
